// ---- logic/sar_adc_conversion_control.v ----
// converter control: register file, clock select/divide, triggers, rounding, blocking
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"

// Overview of operation
// - 8-bit pin disable register, bit 7 channel 23 down to bit 0 channel 16
// - disabled pin: output tristated, input and pullup off, port read zero
// - converter off in reset and when channel select is all ones; idle after done
// - raw 11 bits in 10-bit mode, 9 bits in 8-bit mode, then rounded
// - result transfer sets complete flag; interrupt only if enabled then
// - clock source bus, bus/2, alternate or internal async; bus after reset
// - selected source divided by 1, 2, 4 or 8 for converter clock
// - bus/2 source with divide by 8 gives bus clock divided by 16
// - internal async clock keeps running in wait and stop3 when selected
// - trigger enable set: each rising trigger edge starts a conversion
// - trigger edge during a conversion is ignored, not queued
// - continuous with hardware trigger: only first edge launches the sequence
// - software mode: write to status control 1 with channel not all ones starts
// - continuous mode restarts after each transfer until aborted
// - 10-bit mode high read, low unread: transfer blocked, flag unset, result lost
// - single conversion, compare on and false: blocking ignored, operation stops
// - any other blocked transfer starts another conversion
// - compare enabled by compare enable bit, works in every mode
// - clock select 00 bus, 01 bus/2, 10 alternate, 11 async
// - mode 00 is 8-bit, 10 is 10-bit, 01 and 11 reserved
// - compare on: flag only if result >= value (greater 1) or < value (greater 0)
module sar_adc_conversion_control (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        alternate_clock_source,
    input  wire        internal_async_clock,
    input  wire        hw_trigger_input,
    input  wire        low_power_wait,
    input  wire [10:0] analog_sample,
    input  wire [7:0]  port_pin_in,
    output reg  [7:0]  port_read_data,
    output reg  [7:0]  pin_output_force_hiz,
    output reg  [7:0]  pin_input_buffer_en,
    output reg  [7:0]  pin_pullup_allow,
    output reg         converter_clock,
    output reg         async_clock_keep_on,
    output reg         converter_active,
    output reg         conversion_irq
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SAMP = 4'b0010;
    localparam [3:0] ST_SAR  = 4'b0100;
    localparam [3:0] ST_XFER = 4'b1000;

    // ==========================================================
    // registers
    reg  [4:0]  channel_select_q;
    reg         conversion_complete_flag_q;
    reg         complete_irq_enable_q;
    reg         continuous_enable_q;
    reg         hw_trigger_enable_q;
    reg         compare_enable_q;
    reg         compare_greater_select_q;
    reg  [1:0]  input_clock_select_q;
    reg  [1:0]  clock_divide_select_q;
    reg  [1:0]  mode_q;
    reg  [9:0]  compare_value_q;
    reg  [9:0]  result_q;
    reg  [7:0]  analog_pin_disable_3_q;
    reg         high_read_q;
    reg  [3:0]  state_q;
    reg  [3:0]  sar_cnt_q;
    reg  [10:0] raw_q;
    reg         seq_on_q;
    reg  [2:0]  trig_sync_q;
    reg  [1:0]  alt_sync_q;
    reg  [1:0]  async_sync_q;
    reg         bus_half_q;
    reg  [2:0]  div_cnt_q;
    reg         src_prev_q;
    reg  [3:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg         aw_have_q;
    reg         w_have_q;
    reg  [7:0]  pin_meta_q;
    reg  [7:0]  pin_sync_q;

    wire       ch_off   = (channel_select_q == `CH_ALL_ONES);
    wire       ten_bit  = (mode_q == `MODE_10BIT);
    // ==========================================================
    // clock source select and divide
    reg src_level;
    always @* begin
        // clock select decode
        // source choice
        case (input_clock_select_q)
            `CLK_BUS:      src_level = ~converter_clock;
            `CLK_BUS_HALF: src_level = bus_half_q;
            `CLK_ALT:      src_level = alt_sync_q[1];
            default:       src_level = async_sync_q[1];
        endcase
    end
    wire src_tick = (input_clock_select_q == `CLK_BUS) ? 1'b1 : (src_level & ~src_prev_q);
    wire [2:0] div_max = (3'h1 << clock_divide_select_q) - 3'h1;
    wire       converter_clock_tick = src_tick && (div_cnt_q >= div_max);

    // ==========================================================
    // rounding and compare
    // round raw value
    wire [10:0] rnd10 = raw_q + 11'h001;
    wire [9:0]  res10 = rnd10[10] ? 10'h3ff : rnd10[10:1];
    wire [9:0]  rnd8  = {1'b0, raw_q[8:0]} + 10'h001;
    wire [7:0]  res8  = rnd8[9] ? 8'hff : rnd8[8:1];
    wire [9:0]  res_n = ten_bit ? res10 : {2'h0, res8};
    wire [9:0]  cmp_v = ten_bit ? compare_value_q : {2'h0, compare_value_q[7:0]};
    wire        ge    = (res_n >= cmp_v);
    wire        cmp_ok = ~compare_enable_q | (compare_greater_select_q ? ge : ~ge);
    wire        blocked = ten_bit & high_read_q;

    // ==========================================================
    // bus decode
    wire        wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire        rd_go = s_axi_arvalid & s_axi_arready;
    wire [31:0] wd    = w_data_q;
    wire [3:0]  widx  = aw_addr_q;
    wire [3:0]  ridx  = s_axi_araddr;
    wire        w_sc1 = wr_go & (widx == `OFS_STATUS_CONTROL_1);
    wire        w_mode = wr_go & ((widx == `OFS_STATUS_CONTROL_2) | (widx == `OFS_CONFIG)
                                  | (widx == `OFS_COMPARE));
    wire        trig_rise = trig_sync_q[1] & ~trig_sync_q[2];
    wire        sw_start = w_sc1 & ~hw_trigger_enable_q & (wd[4:0] != `CH_ALL_ONES);
    wire        hw_start = hw_trigger_enable_q & trig_rise & ~ch_off & (state_q == ST_IDLE)
                           & ~seq_on_q;
    wire        xfer_now = (state_q == ST_XFER);
    wire        do_xfer  = xfer_now & cmp_ok & ~blocked;
    wire        restart  = xfer_now & ~ch_off & ((continuous_enable_q & cmp_ok)
                           | (cmp_ok & blocked) | (~cmp_ok & continuous_enable_q)
                           | (~cmp_ok & ~continuous_enable_q & 1'b0));

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (ridx)
            `OFS_STATUS_CONTROL_1:
                rd_mux = {24'h0, conversion_complete_flag_q, complete_irq_enable_q,
                          continuous_enable_q, channel_select_q};
            `OFS_STATUS_CONTROL_2:
                rd_mux = {24'h0, converter_active, hw_trigger_enable_q, compare_enable_q,
                          compare_greater_select_q, 4'h0};
            `OFS_CONFIG:
                rd_mux = {24'h0, 1'b0, clock_divide_select_q, 1'b0, mode_q,
                          input_clock_select_q};
            `OFS_COMPARE:      rd_mux = {22'h0, compare_value_q};
            `OFS_RESULT_HIGH:  rd_mux = {30'h0, ten_bit ? result_q[9:8] : 2'h0};
            `OFS_RESULT_LOW:   rd_mux = {24'h0, result_q[7:0]};
            `OFS_PIN_DISABLE_3: rd_mux = {24'h0, analog_pin_disable_3_q};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // main sequential logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0;
            channel_select_q <= `RST_CHANNEL;
            conversion_complete_flag_q <= 1'b0;
            complete_irq_enable_q <= 1'b0;
            continuous_enable_q <= 1'b0;
            hw_trigger_enable_q <= 1'b0;
            compare_enable_q <= 1'b0;
            compare_greater_select_q <= 1'b0;
            input_clock_select_q <= `CLK_BUS;
            clock_divide_select_q <= 2'h0;
            mode_q <= `MODE_8BIT;
            compare_value_q <= 10'h0;
            result_q <= 10'h0;
            analog_pin_disable_3_q <= `RST_PIN_DISABLE;
            high_read_q <= 1'b0;
            state_q <= ST_IDLE;
            sar_cnt_q <= 4'h0;
            raw_q <= 11'h0;
            seq_on_q <= 1'b0;
            trig_sync_q <= 3'h0;
            alt_sync_q <= 2'h0;
            async_sync_q <= 2'h0;
            bus_half_q <= 1'b0;
            div_cnt_q <= 3'h0;
            src_prev_q <= 1'b0;
            converter_clock <= 1'b0;
            async_clock_keep_on <= 1'b0;
            converter_active <= 1'b0;
            conversion_irq <= 1'b0;
            port_read_data <= 8'h0;
            pin_meta_q <= 8'h0;
            pin_sync_q <= 8'h0;
            pin_output_force_hiz <= 8'h0;
            pin_input_buffer_en <= 8'hff;
            pin_pullup_allow <= 8'hff;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], hw_trigger_input};
            alt_sync_q <= {alt_sync_q[0], alternate_clock_source};
            async_sync_q <= {async_sync_q[0], internal_async_clock};
            bus_half_q <= ~bus_half_q;
            src_prev_q <= src_level;
            if (src_tick)
                div_cnt_q <= (div_cnt_q >= div_max) ? 3'h0 : div_cnt_q + 3'h1;
            // one pulse per tick
            // bus source at ratio 1 can only show half rate on this pin
            converter_clock <= converter_clock_tick & ~converter_clock;
            // async clock held on in low power
            async_clock_keep_on <= (input_clock_select_q == `CLK_ASYNC)
                                   & (converter_active | low_power_wait);
            // write channels
            if (s_axi_awvalid & ~aw_have_q & ~s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else
                s_axi_awready <= 1'b0;
            if (s_axi_awvalid & s_axi_awready)
                aw_have_q <= 1'b1;
            if (s_axi_wvalid & ~w_have_q & ~s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_data_q <= s_axi_wdata;
            end else
                s_axi_wready <= 1'b0;
            if (s_axi_wvalid & s_axi_wready)
                w_have_q <= 1'b1;
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (widx > `OFS_ANALOG_SAMPLE) ? 2'h2 : 2'h0;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go & s_axi_wstrb[0]) begin
                case (widx)
                    `OFS_STATUS_CONTROL_1: begin
                        complete_irq_enable_q <= wd[`SC1_COMPLETE_IRQ_ENABLE_BIT];
                        continuous_enable_q <= wd[`SC1_CONTINUOUS_ENABLE_BIT];
                        channel_select_q <= wd[4:0];
                    end
                    `OFS_STATUS_CONTROL_2: begin
                        hw_trigger_enable_q <= wd[`SC2_TRG_BIT];
                        compare_enable_q <= wd[`SC2_CFE_BIT];
                        compare_greater_select_q <= wd[`SC2_CFGT_BIT];
                    end
                    `OFS_CONFIG: begin
                        clock_divide_select_q <= wd[6:5];
                        mode_q <= wd[3:2];
                        input_clock_select_q <= wd[1:0];
                    end
                    `OFS_COMPARE: compare_value_q <= wd[9:0];
                    `OFS_PIN_DISABLE_3: analog_pin_disable_3_q <= wd[7:0];
                    default: ;
                endcase
            end
            // read channel
            if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid)
                s_axi_arready <= 1'b1;
            else
                s_axi_arready <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (ridx > `OFS_ANALOG_SAMPLE) ? 2'h2 : 2'h0;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (rd_go & (ridx == `OFS_RESULT_HIGH) & ten_bit)
                high_read_q <= 1'b1;
            else if (rd_go & (ridx == `OFS_RESULT_LOW))
                high_read_q <= 1'b0;
            // conversion sequencer
            case (state_q)
                ST_IDLE: begin
                    if (hw_start | sw_start) begin
                        state_q <= ST_SAMP;
                        seq_on_q <= continuous_enable_q | (sw_start & wd[`SC1_CONTINUOUS_ENABLE_BIT]);
                    end
                end
                ST_SAMP: begin
                    if (converter_clock_tick) begin
                        raw_q <= ten_bit ? analog_sample : {2'h0, analog_sample[10:2]};
                        sar_cnt_q <= 4'h0;
                        state_q <= ST_SAR;
                    end
                end
                ST_SAR: begin
                    if (converter_clock_tick) begin
                        sar_cnt_q <= sar_cnt_q + 4'h1;
                        if (sar_cnt_q == `SAR_CYCLES)
                            state_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    state_q <= restart ? ST_SAMP : ST_IDLE;
                    if (~restart)
                        seq_on_q <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
            // aborts: mode writes, status control 1 writes or channel off
            if (w_mode | ((w_sc1 | ch_off) & (state_q != ST_IDLE) & ~sw_start)) begin
                state_q <= ST_IDLE;
                seq_on_q <= 1'b0;
            end
            if (w_sc1 & sw_start) begin
                state_q <= ST_SAMP;
                seq_on_q <= wd[`SC1_CONTINUOUS_ENABLE_BIT];
            end
            converter_active <= (state_q != ST_IDLE) & ~ch_off;
            // transfer sets flag, set wins over clear
            if (do_xfer) begin
                result_q <= res_n;
                conversion_complete_flag_q <= 1'b1;
                conversion_irq <= complete_irq_enable_q;
            end else begin
                if (w_sc1 | (rd_go & (ridx == `OFS_RESULT_LOW)))
                    conversion_complete_flag_q <= 1'b0;
                if (w_sc1 | (rd_go & (ridx == `OFS_RESULT_LOW)) | ~complete_irq_enable_q)
                    conversion_irq <= 1'b0;
            end
            pin_output_force_hiz <= analog_pin_disable_3_q;
            pin_input_buffer_en <= ~analog_pin_disable_3_q;
            pin_pullup_allow <= ~analog_pin_disable_3_q;
            // pin levels pass two flops before use
            pin_meta_q <= port_pin_in;
            pin_sync_q <= pin_meta_q;
            port_read_data <= pin_sync_q & ~analog_pin_disable_3_q;
        end
    end
endmodule // sar_adc_conversion_control

// ---- logic/adc_ctrl_regs.vh ----
// register offsets, fields, reset values and timing counts for the converter control
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH
`define OFS_STATUS_CONTROL_1   4'h0
`define OFS_STATUS_CONTROL_2   4'h1
`define OFS_CONFIG             4'h2
`define OFS_COMPARE            4'h3
`define OFS_RESULT_HIGH        4'h4
`define OFS_RESULT_LOW         4'h5
`define OFS_PIN_DISABLE_3      4'h6
`define OFS_ANALOG_SAMPLE      4'h7
`define SC1_CONVERSION_COMPLETE_FLAG_BIT           7
`define SC1_COMPLETE_IRQ_ENABLE_BIT           6
`define SC1_CONTINUOUS_ENABLE_BIT           5
`define SC2_TRG_BIT            6
`define SC2_CFE_BIT            5
`define SC2_CFGT_BIT           4
`define CH_ALL_ONES            5'h1f
`define RST_CHANNEL            5'h1f
`define RST_PIN_DISABLE        8'h00
`define CLK_BUS                2'h0
`define CLK_BUS_HALF           2'h1
`define CLK_ALT                2'h2
`define CLK_ASYNC              2'h3
`define MODE_8BIT              2'h0
`define MODE_10BIT             2'h2
`define SAR_CYCLES             4'h2
`endif

// ---- tb/sar_adc_conversion_control_sva.sv ----
// assertion checker for the converter control ports
`timescale 1ns/1ps
module adc_ctrl_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_arready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [1:0]  s_axi_rresp,
    input wire [31:0] s_axi_rdata,
    input wire [7:0]  port_read_data,
    input wire [7:0]  pin_output_force_hiz,
    input wire [7:0]  pin_input_buffer_en,
    input wire [7:0]  pin_pullup_allow,
    input wire        converter_active,
    input wire        conversion_irq
);
    // ==========================================
    // bus handshake
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    chk_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_aw_pulse:
        assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
    chk_read_follows:
        assert property ($rose(s_axi_arready) |=> s_axi_rvalid) else $error("read data late");
    chk_slverr_data:
        assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    // ==========================================
    // pins and conversion status
    chk_pin_buffers:
        assert property (pin_input_buffer_en == ~pin_output_force_hiz
            && pin_pullup_allow == pin_input_buffer_en) else $error("pin buffers disagree");
    chk_pin_read_zero:
        assert property ((port_read_data & pin_output_force_hiz & $past(pin_output_force_hiz)) == 8'h0)
        else $error("disabled pin reads nonzero");
    chk_reset_idle:
        assert property ($rose(aresetn) |-> !converter_active && !conversion_irq)
        else $error("converter not idle after reset");
    chk_irq_source:
        assert property ($rose(conversion_irq) |-> $past(converter_active))
        else $error("interrupt without conversion");
endmodule // adc_ctrl_checker

bind sar_adc_conversion_control adc_ctrl_checker chk_i (.aclk, .aresetn, .s_axi_awready,
    .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rresp, .s_axi_rdata, .port_read_data, .pin_output_force_hiz, .pin_input_buffer_en,
    .pin_pullup_allow, .converter_active, .conversion_irq);

// ---- tb/analog_front_model.sv ----
// far-side model: pin levels, source clocks and hardware trigger
`timescale 1ns/1ps
module analog_front_model (
    output logic       alternate_clock_source,
    output logic       internal_async_clock,
    output logic       hw_trigger_input,
    output logic [7:0] port_pin_in
);
    // ==========================================
    // free-running sources unrelated to the bus clock
    initial begin
        alternate_clock_source = 1'b0;
        forever #31 alternate_clock_source = ~alternate_clock_source;
    end
    initial begin
        internal_async_clock = 1'b0;
        forever #17.3 internal_async_clock = ~internal_async_clock;
    end
    initial begin
        hw_trigger_input = 1'b0;
        port_pin_in = 8'hff;
    end
    task fire;
        #7.3 hw_trigger_input = 1'b1;
        #53 hw_trigger_input = 1'b0;
    endtask
endmodule // analog_front_model

// ---- tb/sar_adc_conversion_control_test.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module sar_adc_conversion_control_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, alternate_clock_source, internal_async_clock, hw_trigger_input;
    logic        low_power_wait, converter_clock, async_clock_keep_on, converter_active;
    logic        conversion_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [7:0]  port_pin_in, port_read_data, pin_output_force_hiz, pin_input_buffer_en;
    logic [7:0]  pin_pullup_allow;
    logic [10:0] analog_sample;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    int          num_errors, n_tests, k;
    localparam logic [3:0] sc1_a = `OFS_STATUS_CONTROL_1;
    localparam logic [3:0] sc2_a = `OFS_STATUS_CONTROL_2;
    localparam logic [3:0] cfg_a = `OFS_CONFIG;
    localparam logic [3:0] res_h = `OFS_RESULT_HIGH;
    localparam logic [3:0] res_l = `OFS_RESULT_LOW;

    sar_adc_conversion_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .alternate_clock_source, .internal_async_clock,
        .hw_trigger_input, .low_power_wait, .analog_sample, .port_pin_in, .port_read_data,
        .pin_output_force_hiz, .pin_input_buffer_en, .pin_pullup_allow, .converter_clock,
        .async_clock_keep_on, .converter_active, .conversion_irq);
    analog_front_model pm (.alternate_clock_source, .internal_async_clock, .hw_trigger_input,
        .port_pin_in);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ==========================================
    // checking and bus tasks
    function automatic logic [31:0] rnd10(input logic [10:0] s);
        return 32'((12'(s) + 12'h1) >> 1);
    endfunction
    function automatic logic [31:0] cfg(input logic [1:0] dv, input logic [1:0] md, ck);
        return {25'h0, dv, 1'b0, md, ck};
    endfunction
    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tmo;
        if (k >= 60) begin
            chk("handshake wait", 32'h0, 32'h1);
            test_done;
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && dd && s_axi_bvalid) && k < 60) begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
                dd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        rrsp = s_axi_bresp;
        tmo;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (!s_axi_arready && k < 60);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid && k < 60) begin
            @(posedge aclk);
            k++;
        end
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        tmo;
        s_axi_rready <= 1'b0;
    endtask
    task rc(input string nm, input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, rdat, e);
    endtask
    task wait_flag;
        int n;
        n = 0;
        rd(sc1_a);
        while (!rdat[7] && n < 100) begin
            rd(sc1_a);
            n++;
        end
        chk("complete flag", 32'(rdat[7]), 32'h1);
    endtask

    // ==========================================
    // main sequence
    initial begin
        int n, d;
        logic p;
        num_errors = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        low_power_wait = 1'b0;
        analog_sample = 11'h2a3;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rc("status 1", sc1_a, 32'h1f);
        rc("config", cfg_a, 32'h0);
        rc("reserved", `OFS_ANALOG_SAMPLE, 32'h0);
        rd(4'h8);
        chk("unmapped", 32'(rrsp), 32'h2);
        wr(4'h8, 32'h0);
        chk("unmapped write", 32'(rrsp), 32'h2);
        wr(`OFS_PIN_DISABLE_3, 32'ha5);
        rc("pin disable", `OFS_PIN_DISABLE_3, 32'ha5);
        chk("hiz", 32'(pin_output_force_hiz), 32'ha5);
        chk("input buffer", 32'(pin_input_buffer_en), 32'h5a);
        chk("pullup", 32'(pin_pullup_allow), 32'h5a);
        chk("port read", 32'(port_read_data), 32'h5a);
        wr(cfg_a, cfg(2'h0, `MODE_10BIT, `CLK_BUS));
        wr(sc1_a, 32'h43);
        wait_flag;
        chk("irq", 32'(conversion_irq), 32'h1);
        chk("idle", 32'(converter_active), 32'h0);
        rc("high 10", res_h, rnd10(11'h2a3) >> 8);
        rc("low 10", res_l, rnd10(11'h2a3) & 32'hff);
        chk("irq clear", 32'(conversion_irq), 32'h0);
        wr(cfg_a, cfg(2'h0, `MODE_8BIT, `CLK_BUS));
        wr(sc1_a, 32'h03);
        wait_flag;
        chk("irq masked", 32'(conversion_irq), 32'h0);
        rc("high 8", res_h, 32'h0);
        rc("low 8", res_l, 32'h54);
        wr(cfg_a, cfg(2'h3, `MODE_10BIT, `CLK_BUS_HALF));
        analog_sample <= 11'h0f0;
        wr(sc1_a, 32'h03);
        rc("early high", res_h, 32'h0);
        repeat (300) @(posedge aclk);
        rc("blocked", sc1_a, 32'h03);
        rc("old low", res_l, 32'h54);
        wait_flag;
        rc("new low", res_l, rnd10(11'h0f0) & 32'hff);
        wr(`OFS_COMPARE, 32'h200);
        wr(sc2_a, 32'h30);
        wr(sc1_a, 32'h03);
        repeat (300) @(posedge aclk);
        rc("compare false", sc1_a, 32'h03);
        chk("stopped", 32'(converter_active), 32'h0);
        wr(sc2_a, 32'h20);
        wr(sc1_a, 32'h03);
        wait_flag;
        rc("compare low", res_l, rnd10(11'h0f0) & 32'hff);
        wr(sc2_a, 32'h40);
        wr(sc1_a, 32'h03);
        repeat (10) @(posedge aclk);
        chk("no write start", 32'(converter_active), 32'h0);
        pm.fire;
        repeat (10) @(posedge aclk);
        pm.fire;
        wait_flag;
        rd(res_l);
        repeat (100) @(posedge aclk);
        rc("edge ignored", sc1_a, 32'h03);
        wr(sc2_a, 32'h0);
        wr(sc1_a, 32'h23);
        wait_flag;
        rd(res_l);
        wait_flag;
        for (d = 0; d < 4; d++) begin
            wr(cfg_a, cfg(d[1:0], `MODE_10BIT, `CLK_BUS_HALF));
            wr(sc1_a, 32'h23);
            n = 0;
            p = converter_clock;
            repeat (160) begin
                @(posedge aclk);
                if (converter_clock && !p) n++;
                p = converter_clock;
            end
            chk("converter clock", 32'(n), 32'(160 >> (d + 1)));
        end
        wr(cfg_a, cfg(2'h0, `MODE_10BIT, `CLK_ASYNC));
        low_power_wait <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("async kept", 32'(async_clock_keep_on), 32'h1);
        wr(cfg_a, cfg(2'h0, `MODE_10BIT, `CLK_BUS));
        repeat (4) @(posedge aclk);
        chk("async dropped", 32'(async_clock_keep_on), 32'h0);
        test_done;
    end
endmodule // sar_adc_conversion_control_test
